/* include/timer_compare_pkg.sv */
package timer_compare_pkg;

    // ********************************
    // Register offsets on the byte port
    // ********************************
    localparam logic [3:0] ADDR_M4_LOW = 4'h0;
    localparam logic [3:0] ADDR_M4_HIGH = 4'h1;
    localparam logic [3:0] ADDR_M5_LOW = 4'h2;
    localparam logic [3:0] ADDR_M5_HIGH = 4'h3;
    localparam logic [3:0] ADDR_M4_CTL = 4'h4;
    localparam logic [3:0] ADDR_M5_CTL = 4'h5;
    localparam logic [3:0] ADDR_SHARED = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h7;
    localparam logic [3:0] ADDR_MASK = 4'h8;
    localparam logic [3:0] ADDR_CONFIG = 4'h9;

    // ********************************
    // Field layouts and reset values
    // ********************************
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] CTL_MASK = 8'h3F;
    localparam logic [7:0] ODS_MASK = 8'h1F;
    localparam logic [7:0] CFG_MASK = 8'h13;
    localparam logic [1:0] FLAG_MASK = 2'h3;
    localparam int CFG_TSEL4_BIT = 0;
    localparam int CFG_TSEL5_BIT = 1;
    localparam int CFG_ALT_MAP_BIT = 4;
    localparam int ODS_M4_BIT = 3;
    localparam int ODS_M5_BIT = 4;
    localparam int FLAG_M4_BIT = 0;
    localparam int FLAG_M5_BIT = 1;

    // ********************************
    // Mode select field codes and capture prescaler limits
    // ********************************
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4TH = 4'h6;
    localparam logic [3:0] MODE_CAP_16TH = 4'h7;
    localparam logic [3:0] MODE_SET_HIGH = 4'h8;
    localparam logic [3:0] MODE_SET_LOW = 4'h9;
    localparam logic [3:0] MODE_SOFT_INT = 4'hA;
    localparam logic [3:0] MODE_SPECIAL = 4'hB;
    localparam logic [3:0] PRESCALE_1 = 4'h0;
    localparam logic [3:0] PRESCALE_4 = 4'h3;
    localparam logic [3:0] PRESCALE_16 = 4'hF;

    // Mode class decoders
    function automatic logic is_compare(input logic [3:0] m);
        return (m == MODE_TOGGLE) || (m[3:2] == 2'h2);
    endfunction

    function automatic logic is_capture(input logic [3:0] m);
        return m[3:2] == 2'h1;
    endfunction

    function automatic logic is_pwm(input logic [3:0] m);
        return m[3:2] == 2'h3;
    endfunction

endpackage

/* verilog/compare_channel.sv */
`timescale 1ns/1ps
module compare_channel (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Register writes
    input wire logic i_wr_ctl,
    input wire logic i_wr_low,
    input wire logic i_wr_high,
    input wire logic [7:0] i_wdata,
    // Time bases and pin input
    input wire logic [15:0] i_timer,
    input wire logic [9:0] i_pwm_count,
    input wire logic i_pwm_period_end,
    input wire logic i_pin_in,
    // Channel state
    output logic [7:0] o_control,
    output logic [15:0] o_value,
    output logic o_match,
    output logic o_special_event,
    output logic o_pin_latch,
    output logic o_drives_pin
);
    logic [3:0] mode;
    logic [3:0] new_mode;
    logic equal_now;
    logic equal_seen;
    logic hit;
    logic pin_seen;
    logic edge_hit;
    logic [3:0] presc_count;
    logic [3:0] presc_limit;
    logic capture;
    logic [1:0] duty_low_bits;

    assign mode = o_control[3:0];
    assign new_mode = i_wdata[3:0];

    // Equality with the selected timer, only in compare modes
    assign equal_now = timer_compare_pkg::is_compare(mode) && (o_value == i_timer); // R1
    // First cycle of equality only, so a stalled timer fires once
    assign hit = equal_now && !equal_seen; // R17
    assign o_match = hit || capture;
    assign o_drives_pin = timer_compare_pkg::is_pwm(mode)
        || (timer_compare_pkg::is_compare(mode) && mode != timer_compare_pkg::MODE_SOFT_INT); // R4

    // Equality history
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            equal_seen <= 1'b0;
        end else begin
            equal_seen <= equal_now;
        end
    end

    // Control register
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_control <= timer_compare_pkg::RESET_BYTE;
        end else if (i_wr_ctl) begin
            o_control <= i_wdata & timer_compare_pkg::CTL_MASK;
        end
    end

    // Capture edge choice and prescaler limit
    assign edge_hit = (mode == timer_compare_pkg::MODE_CAP_FALL) ? (pin_seen && !i_pin_in)
        : (!pin_seen && i_pin_in);
    always_comb begin
        unique case (mode)
            timer_compare_pkg::MODE_CAP_4TH: presc_limit = timer_compare_pkg::PRESCALE_4;
            timer_compare_pkg::MODE_CAP_16TH: presc_limit = timer_compare_pkg::PRESCALE_16;
            default: presc_limit = timer_compare_pkg::PRESCALE_1;
        endcase
    end
    assign capture = timer_compare_pkg::is_capture(mode) && edge_hit
        && (presc_count == presc_limit); // R15

    // Prescaler survives a switch between capture modes; only leaving capture clears it
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_seen <= 1'b0;
            presc_count <= 4'h0;
        end else begin
            pin_seen <= i_pin_in;
            if (!timer_compare_pkg::is_capture(mode)) begin
                presc_count <= 4'h0; // R14
            end else if (edge_hit) begin
                presc_count <= capture ? 4'h0 : presc_count + 4'h1;
            end
        end
    end

    // Data pair; in pulse-width mode the high byte is the buffered duty and read-only
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_value <= 16'h0000;
        end else if (capture) begin
            o_value <= i_timer;
        end else begin
            if (i_wr_low) begin
                o_value[7:0] <= i_wdata;
            end
            if (timer_compare_pkg::is_pwm(mode) && i_pwm_period_end) begin
                o_value[15:8] <= o_value[7:0]; // R10
            end else if (i_wr_high && !timer_compare_pkg::is_pwm(mode)) begin
                o_value[15:8] <= i_wdata;
            end
        end
    end

    // Two-bit duty buffer beside the high byte
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            duty_low_bits <= 2'h0;
        end else if (mode == timer_compare_pkg::MODE_OFF) begin
            duty_low_bits <= 2'h0;
        end else if (timer_compare_pkg::is_pwm(mode) && i_pwm_period_end) begin
            duty_low_bits <= o_control[5:4]; // R10
        end
    end

    // Dedicated output latch, apart from the port data latch
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pin_latch <= 1'b0;
        end else if (i_wr_ctl && new_mode == timer_compare_pkg::MODE_OFF) begin
            o_pin_latch <= 1'b0; // R8 R9 R14
        end else if (i_wr_ctl && new_mode != mode
                && new_mode == timer_compare_pkg::MODE_SET_HIGH) begin
            o_pin_latch <= 1'b0; // R13
        end else if (i_wr_ctl && new_mode != mode
                && new_mode == timer_compare_pkg::MODE_SET_LOW) begin
            o_pin_latch <= 1'b1; // R13
        end else if (timer_compare_pkg::is_pwm(mode)) begin
            if (i_pwm_period_end) begin
                o_pin_latch <= {o_value[7:0], o_control[5:4]} != 10'h000; // R10
            end else if ({o_value[15:8], duty_low_bits} == i_pwm_count) begin
                o_pin_latch <= 1'b0; // R10
            end
        end else if (hit) begin
            unique case (mode)
                timer_compare_pkg::MODE_TOGGLE: o_pin_latch <= !o_pin_latch; // R2 R13
                timer_compare_pkg::MODE_SET_HIGH: o_pin_latch <= 1'b1; // R2 R13
                timer_compare_pkg::MODE_SET_LOW: o_pin_latch <= 1'b0; // R2 R13
                default: o_pin_latch <= o_pin_latch;
            endcase
        end
    end

    // Special event pulse, aligned with the flag
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_special_event <= 1'b0;
        end else begin
            o_special_event <= hit && mode == timer_compare_pkg::MODE_SPECIAL; // R13
        end
    end

endmodule

/* verilog/timer_compare_unit.sv */
// Behaviour
// R1 - Compare the 16-bit data pair with the selected timer every cycle.
// R2 - On match drive high, drive low, toggle, or leave pin to port latch.
// R3 - Match flag is set in the same cycle as the pin action.
// R4 - Software-interrupt compare code leaves the pin untouched.
// R5 - Software-interrupt match only requests interrupt, gated by its enable bit.
// R6 - Software runs the timer synchronised to the system clock.
// R7 - Software clears the port direction bit before using pin actions.
// R8 - Writing zero to module 5 control forces its compare latch low.
// R9 - Writing zero to module 4 or 5 control forces its output latch low.
// R10 - Pulse-width output uses a ten-bit duty cycle.
// R11 - Software switches capture prescaler by writing zero, then the new mode.
// R12 - Shared address shows open-drain select when alternate map bit is one.
// R13 - Codes: 0010 toggle, 1000 low-then-high, 1001 high-then-low, 1011 special event.
// R14 - Mode zero disables the module and clears its internal state.
// R15 - Capture codes 0100 to 0111 and pulse-width codes 11xx.
// R16 - Match flag stays set until software clears it.
// R17 - One match per timer value, not repeated while the timer stalls.
`timescale 1ns/1ps
module timer_compare_unit (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Shared time bases
    input wire logic [15:0] i_first_shared_timer,
    input wire logic [15:0] i_second_shared_timer,
    input wire logic [9:0] i_pwm_count4,
    input wire logic i_pwm_period_end4,
    input wire logic [9:0] i_pwm_count5,
    input wire logic i_pwm_period_end5,
    // Port latch and direction, bit 0 module 4, bit 1 module 5
    input wire logic [1:0] i_port_latch,
    input wire logic [1:0] i_port_direction_bit,
    // Module pins
    input wire logic i_module4_pin,
    output logic o_module4_pin,
    output logic o_module4_pin_oe,
    input wire logic i_module5_pin,
    output logic o_module5_pin,
    output logic o_module5_pin_oe,
    // Events
    output logic [1:0] o_special_event,
    output logic o_irq
);

    // ********************************
    // Declarations
    // ********************************
    logic wr_low4;
    logic wr_high4;
    logic wr_ctl4;
    logic wr_low5;
    logic wr_high5;
    logic wr_ctl5;
    logic alt_map;
    logic [7:0] config_bits;
    logic [7:0] open_drain_select;
    logic [1:0] match_event_flag;
    logic [1:0] match_event_enable;
    logic [1:0] flag_clear;
    logic [15:0] timer4;
    logic [15:0] timer5;
    logic [7:0] ctl4;
    logic [7:0] ctl5;
    logic [15:0] value4;
    logic [15:0] value5;
    logic match4;
    logic match5;
    logic latch4;
    logic latch5;
    logic drives4;
    logic drives5;
    logic level4;
    logic level5;
    logic [7:0] next_rdata;

    // Pin drive: {value, enable}; open-drain only ever pulls low
    function automatic logic [1:0] pin_drive(input logic level, input logic od,
            input logic dir);
        logic [1:0] r;
        r[1] = od ? 1'b0 : level;
        r[0] = !dir && (!od || !level);
        return r;
    endfunction

    // ********************************
    // Register port decode
    // ********************************
    // Writes are single-cycle strobes; no wait states
    assign wr_low4 = i_wr && i_addr == timer_compare_pkg::ADDR_M4_LOW;
    assign wr_high4 = i_wr && i_addr == timer_compare_pkg::ADDR_M4_HIGH;
    assign wr_ctl4 = i_wr && i_addr == timer_compare_pkg::ADDR_M4_CTL;
    assign wr_low5 = i_wr && i_addr == timer_compare_pkg::ADDR_M5_LOW;
    assign wr_high5 = i_wr && i_addr == timer_compare_pkg::ADDR_M5_HIGH;
    assign wr_ctl5 = i_wr && i_addr == timer_compare_pkg::ADDR_M5_CTL;
    assign alt_map = config_bits[timer_compare_pkg::CFG_ALT_MAP_BIT];

    // Timer selection and map switch
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            config_bits <= timer_compare_pkg::RESET_BYTE;
        end else if (i_wr && i_addr == timer_compare_pkg::ADDR_CONFIG) begin
            config_bits <= i_wdata & timer_compare_pkg::CFG_MASK;
        end
    end

    // Open-drain select; writable only while mapped in, the timer byte is not ours
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            open_drain_select <= timer_compare_pkg::RESET_BYTE;
        end else if (i_wr && i_addr == timer_compare_pkg::ADDR_SHARED && alt_map) begin
            open_drain_select <= i_wdata & timer_compare_pkg::ODS_MASK; // R12
        end
    end

    // ********************************
    // Timer routing
    // ********************************
    // Which shared timer each module watches
    assign timer4 = config_bits[timer_compare_pkg::CFG_TSEL4_BIT]
        ? i_second_shared_timer : i_first_shared_timer; // R1
    assign timer5 = config_bits[timer_compare_pkg::CFG_TSEL5_BIT]
        ? i_second_shared_timer : i_first_shared_timer; // R1

    // ********************************
    // Channels
    // ********************************
    compare_channel chan4 (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_wr_ctl(wr_ctl4),
        .i_wr_low(wr_low4),
        .i_wr_high(wr_high4),
        .i_wdata(i_wdata),
        .i_timer(timer4),
        .i_pwm_count(i_pwm_count4),
        .i_pwm_period_end(i_pwm_period_end4),
        .i_pin_in(i_module4_pin),
        .o_control(ctl4),
        .o_value(value4),
        .o_match(match4),
        .o_special_event(o_special_event[0]),
        .o_pin_latch(latch4),
        .o_drives_pin(drives4)
    );

    compare_channel chan5 (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_wr_ctl(wr_ctl5),
        .i_wr_low(wr_low5),
        .i_wr_high(wr_high5),
        .i_wdata(i_wdata),
        .i_timer(timer5),
        .i_pwm_count(i_pwm_count5),
        .i_pwm_period_end(i_pwm_period_end5),
        .i_pin_in(i_module5_pin),
        .o_control(ctl5),
        .o_value(value5),
        .o_match(match5),
        .o_special_event(o_special_event[1]),
        .o_pin_latch(latch5),
        .o_drives_pin(drives5)
    );

    // ********************************
    // Pins
    // ********************************
    // Outside an output mode the pin follows the port latch
    assign level4 = drives4 ? latch4 : i_port_latch[0]; // R2 R4
    assign level5 = drives5 ? latch5 : i_port_latch[1]; // R2 R4
    assign {o_module4_pin, o_module4_pin_oe} = pin_drive(level4,
        open_drain_select[timer_compare_pkg::ODS_M4_BIT], i_port_direction_bit[0]);
    assign {o_module5_pin, o_module5_pin_oe} = pin_drive(level5,
        open_drain_select[timer_compare_pkg::ODS_M5_BIT], i_port_direction_bit[1]);

    // ********************************
    // Interrupt flags and enables
    // ********************************
    assign flag_clear = (i_wr && i_addr == timer_compare_pkg::ADDR_STATUS)
        ? i_wdata[1:0] : 2'h0;

    // Sticky flags; a match beside a clear wins so no event is lost
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            match_event_flag <= 2'h0;
        end else begin
            match_event_flag <= (match_event_flag & ~flag_clear) | {match5, match4}; // R3 R16
        end
    end

    // Enable bits of the same layout
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            match_event_enable <= 2'h0;
        end else if (i_wr && i_addr == timer_compare_pkg::ADDR_MASK) begin
            match_event_enable <= i_wdata[1:0] & timer_compare_pkg::FLAG_MASK;
        end
    end

    // Level request while any enabled flag stands
    assign o_irq = |(match_event_flag & match_event_enable); // R5

    // ********************************
    // Read data
    // ********************************
    always_comb begin
        next_rdata = timer_compare_pkg::RESET_BYTE;
        unique case (i_addr)
            timer_compare_pkg::ADDR_M4_LOW: next_rdata = value4[7:0];
            timer_compare_pkg::ADDR_M4_HIGH: next_rdata = value4[15:8];
            timer_compare_pkg::ADDR_M5_LOW: next_rdata = value5[7:0];
            timer_compare_pkg::ADDR_M5_HIGH: next_rdata = value5[15:8];
            timer_compare_pkg::ADDR_M4_CTL: next_rdata = ctl4;
            timer_compare_pkg::ADDR_M5_CTL: next_rdata = ctl5;
            timer_compare_pkg::ADDR_SHARED: begin
                next_rdata = alt_map ? open_drain_select : i_first_shared_timer[15:8]; // R12
            end
            timer_compare_pkg::ADDR_STATUS: next_rdata = {6'h00, match_event_flag};
            timer_compare_pkg::ADDR_MASK: next_rdata = {6'h00, match_event_enable};
            timer_compare_pkg::ADDR_CONFIG: next_rdata = config_bits;
            default: next_rdata = timer_compare_pkg::RESET_BYTE;
        endcase
    end

    // Data stand one cycle after the strobe and read as zero otherwise
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= timer_compare_pkg::RESET_BYTE;
        end else begin
            o_rdata <= i_rd ? next_rdata : timer_compare_pkg::RESET_BYTE;
        end
    end

    // ********************************
    // Checks
    // ********************************
    default clocking chk_clk @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    // A compare match is only ever on the selected count
    compare_equal_a: assert property ( // R1
        match4 && timer_compare_pkg::is_compare(ctl4[3:0]) |-> value4 == timer4
    ) else $error("match without equal count");

    // Toggle inverts the latch on the next edge
    toggle_action_a: assert property ( // R2
        match4 && ctl4[3:0] == timer_compare_pkg::MODE_TOGGLE && !wr_ctl4
        |=> latch4 != $past(latch4)
    ) else $error("toggle did not invert latch");

    // Flag rises on the same edge as the pin action
    flag_with_action_a: assert property ( // R3
        match5 |=> match_event_flag[1]
    ) else $error("flag not set with match");

    // Software-interrupt mode pin follows the port latch
    soft_int_pin_a: assert property ( // R4
        ctl4[3:0] == timer_compare_pkg::MODE_SOFT_INT |-> level4 == i_port_latch[0]
    ) else $error("pin moved in software interrupt mode");

    // An enabled match raises the request one edge later
    irq_enabled_a: assert property ( // R5
        match4 && match_event_enable[0] && !(i_wr && i_addr == timer_compare_pkg::ADDR_MASK)
        |=> o_irq
    ) else $error("enabled match gave no request");

    // Clearing module 5 control drops its latch
    clear_latch_a: assert property ( // R8
        wr_ctl5 && i_wdata[3:0] == timer_compare_pkg::MODE_OFF |=> !latch5 [*2]
    ) else $error("latch not low after clear");

    // Period start sets the pin for any non-zero duty
    pwm_start_a: assert property ( // R10
        timer_compare_pkg::is_pwm(ctl4[3:0]) && i_pwm_period_end4 && !wr_ctl4
        && {value4[7:0], ctl4[5:4]} != 10'h000 |=> latch4
    ) else $error("period start did not set pin");

    // Default map shows the timer high byte
    shared_read_a: assert property ( // R12
        i_rd && i_addr == timer_compare_pkg::ADDR_SHARED && !alt_map
        |=> o_rdata == $past(i_first_shared_timer[15:8])
    ) else $error("shared address read wrong source");

    // Low-then-high mode ends high after a match
    set_high_a: assert property ( // R13
        match4 && ctl4[3:0] == timer_compare_pkg::MODE_SET_HIGH && !wr_ctl4 |=> latch4
    ) else $error("set-high mode left latch low");

    // Flags hold until a one is written to them
    flag_sticky_a: assert property ( // R16
        match_event_flag[0] && !flag_clear[0] |=> match_event_flag[0]
    ) else $error("flag dropped without clear");

    // Disabling stops all matches
    mode_off_a: assert property ( // R14
        wr_ctl4 && i_wdata[3:0] == timer_compare_pkg::MODE_OFF |=> !match4
    ) else $error("match while disabled");

    // No two matches on back-to-back edges
    single_match_a: assert property ( // R17
        match4 && timer_compare_pkg::is_compare(ctl4[3:0]) && !wr_low4 && !wr_high4
        |=> !match4
    ) else $error("repeated match");

endmodule

/* tb/pin_load.sv */
`timescale 1ns/1ps
module pin_load (
    // Unit side
    input wire logic i_pin,
    input wire logic i_oe,
    // Line seen by the unit
    output logic o_level
);
    // Pull-up takes the line whenever the unit lets go, so no stale value lingers
    assign o_level = i_oe ? i_pin : 1'b1;
endmodule

/* tb/timer_compare_unit_test.sv */
`timescale 1ns/1ps
module timer_compare_unit_test;
    // ****************
    // Signals
    // ****************
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [15:0] t_a = 16'h0000;
    logic [15:0] t_b = 16'h0000;
    logic [1:0] port_latch = 2'h0;
    logic pe4 = 1'b0;
    logic [7:0] o_rdata;
    logic p4, oe4, p5, oe5, l4, l5, irq, rd_seen;
    logic [1:0] sev;
    logic [7:0] exp_q[$];
    logic [15:0] v;
    int err_count = 0;
    int tests_run = 0;

    // Free-running system clock
    always #5 i_clk_sys = ~i_clk_sys;

    timer_compare_unit dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_first_shared_timer(t_a), .i_second_shared_timer(t_b),
        .i_pwm_count4(10'h000), .i_pwm_period_end4(pe4), .i_pwm_count5(10'h000),
        .i_pwm_period_end5(1'b0), .i_port_latch(port_latch), .i_port_direction_bit(2'h0),
        .i_module4_pin(l4), .o_module4_pin(p4), .o_module4_pin_oe(oe4),
        .i_module5_pin(l5), .o_module5_pin(p5), .o_module5_pin_oe(oe5),
        .o_special_event(sev), .o_irq(irq));
    pin_load load4 (.i_pin(p4), .i_oe(oe4), .o_level(l4));
    pin_load load5 (.i_pin(p5), .i_oe(oe5), .o_level(l5));

    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
    endtask
    // Timer sits on the value for four cycles; only one match may count
    task automatic hit(input bit b, input logic [15:0] x);
        @(posedge i_clk_sys);
        if (b) t_b <= x; else t_a <= x;
        repeat (4) @(posedge i_clk_sys);
        if (b) t_b <= x + 16'h0001; else t_a <= x + 16'h0001;
        @(negedge i_clk_sys);
    endtask
    task automatic end_of_test();
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe, so look mid-cycle
    always @(posedge i_clk_sys) rd_seen <= i_rd;
    always @(negedge i_clk_sys) begin
        if (rd_seen) begin
            chk(o_rdata, exp_q.pop_front());
        end
    end

    // Watchdog, far beyond the roughly 120 cycles the sequence needs
    initial begin
        #50000;
        err_count++;
        end_of_test();
    end

    // ****************
    // Sequence
    // ****************
    initial begin
        void'($urandom(32'h51A1));
        v = {1'b1, 15'($urandom)};
        port_latch <= 2'($urandom);
        repeat (6) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rd(timer_compare_pkg::ADDR_STATUS, 8'h00);
        rd(4'hF, 8'h00);
        wr(timer_compare_pkg::ADDR_MASK, 8'h03);
        wr(timer_compare_pkg::ADDR_M4_LOW, v[7:0]);
        wr(timer_compare_pkg::ADDR_M4_HIGH, v[15:8]);
        wr(timer_compare_pkg::ADDR_M4_CTL, {4'h0, timer_compare_pkg::MODE_SET_HIGH});
        @(negedge i_clk_sys) chk({7'h0, p4}, 8'h00);
        hit(0, v);
        chk({7'h0, p4}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        rd(timer_compare_pkg::ADDR_STATUS, 8'h01);
        wr(timer_compare_pkg::ADDR_STATUS, 8'h01);
        rd(timer_compare_pkg::ADDR_STATUS, 8'h00);
        // Module 5 on the second timer; the first timer must not move it
        wr(timer_compare_pkg::ADDR_CONFIG, 8'h02);
        wr(timer_compare_pkg::ADDR_M5_LOW, v[7:0]);
        wr(timer_compare_pkg::ADDR_M5_HIGH, v[15:8]);
        wr(timer_compare_pkg::ADDR_M5_CTL, {4'h0, timer_compare_pkg::MODE_SET_LOW});
        @(negedge i_clk_sys) chk({7'h0, p5}, 8'h01);
        hit(0, v);
        chk({7'h0, p5}, 8'h01);
        hit(1, v);
        chk({7'h0, p5}, 8'h00);
        wr(timer_compare_pkg::ADDR_M4_CTL, {4'h0, timer_compare_pkg::MODE_TOGGLE});
        hit(0, v);
        chk({7'h0, p4}, 8'h00);
        hit(0, v);
        chk({7'h0, p4}, 8'h01);
        // Software interrupt: pin follows the port latch, irq only when enabled
        wr(timer_compare_pkg::ADDR_M4_CTL, {4'h0, timer_compare_pkg::MODE_SOFT_INT});
        wr(timer_compare_pkg::ADDR_STATUS, 8'h03);
        wr(timer_compare_pkg::ADDR_MASK, 8'h00);
        hit(0, v);
        chk({7'h0, p4}, {7'h0, port_latch[0]});
        chk({7'h0, irq}, 8'h00);
        wr(timer_compare_pkg::ADDR_MASK, 8'h01);
        @(negedge i_clk_sys) chk({7'h0, irq}, 8'h01);
        // A rising pin edge in capture mode loads the running count
        wr(timer_compare_pkg::ADDR_M4_CTL, {4'h0, timer_compare_pkg::MODE_CAP_RISE});
        port_latch <= 2'h0;
        @(posedge i_clk_sys) port_latch <= 2'h3;
        rd(timer_compare_pkg::ADDR_M4_LOW, t_a[7:0]);
        // Period end sets the pin and moves the duty into the high byte
        wr(timer_compare_pkg::ADDR_M4_LOW, 8'h40);
        wr(timer_compare_pkg::ADDR_M4_CTL, 8'h0C);
        @(posedge i_clk_sys) pe4 <= 1'b1;
        @(posedge i_clk_sys) pe4 <= 1'b0;
        @(negedge i_clk_sys) chk({7'h0, p4}, 8'h01);
        rd(timer_compare_pkg::ADDR_M4_HIGH, 8'h40);
        wr(timer_compare_pkg::ADDR_M5_CTL, {4'h0, timer_compare_pkg::MODE_SPECIAL});
        @(posedge i_clk_sys) t_b <= v;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys) chk({6'h0, sev}, 8'h02);
        @(negedge i_clk_sys) chk({6'h0, sev}, 8'h00);
        @(posedge i_clk_sys) t_b <= v + 16'h0001;
        // Clearing control forces the output latch low
        wr(timer_compare_pkg::ADDR_M5_CTL, {4'h0, timer_compare_pkg::MODE_TOGGLE});
        hit(1, v);
        chk({7'h0, p5}, 8'h01);
        wr(timer_compare_pkg::ADDR_M5_CTL, 8'h00);
        wr(timer_compare_pkg::ADDR_M5_CTL, {4'h0, timer_compare_pkg::MODE_TOGGLE});
        @(negedge i_clk_sys) chk({7'h0, p5}, 8'h00);
        rd(timer_compare_pkg::ADDR_M5_CTL, {4'h0, timer_compare_pkg::MODE_TOGGLE});
        // Shared address swaps with the alternate map bit
        wr(timer_compare_pkg::ADDR_SHARED, 8'h18);
        rd(timer_compare_pkg::ADDR_SHARED, t_a[15:8]);
        wr(timer_compare_pkg::ADDR_CONFIG, 8'h10);
        wr(timer_compare_pkg::ADDR_SHARED, 8'h18);
        rd(timer_compare_pkg::ADDR_SHARED, 8'h18);
        // Open-drain pins only ever pull low: high level lets go, low level drives
        @(negedge i_clk_sys) chk({4'h0, oe4, p4, oe5, p5}, 8'h02);
        wr(timer_compare_pkg::ADDR_CONFIG, 8'h00);
        rd(timer_compare_pkg::ADDR_SHARED, t_a[15:8]);
        repeat (3) @(posedge i_clk_sys);
        end_of_test();
    end
endmodule
